// File: src/scr_defines.svh
// Constants for the serial channel readout and test control block
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

`define SCR_NCHAN          64
`define SCR_LAST_CHAN      6'h3F
`define SCR_IDX_W          6
`define SCR_TRIM_W         4
`define SCR_CFG_LEN        324
// Configuration chain layout, first bit shifted in ends at the top
`define SCR_CFG_TESTON     323
`define SCR_CFG_WOR        322
`define SCR_CFG_NEGTHR     321
`define SCR_CFG_MONBUF     320
`define SCR_CFG_DIS_HI     319
`define SCR_CFG_DIS_LO     256
`define SCR_CFG_TRIM_HI    255
// Timing
`define SCR_CLK_PERIOD_NS  20
`define SCR_PW_DEFAULT_NS  50
`define SCR_PW_CYCLES \
  ((`SCR_PW_DEFAULT_NS + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS)
`define SCR_PW_W           2
// APB byte offsets
`define SCR_ADDR_W         8
`define SCR_OFS_STATUS     8'h00
`define SCR_OFS_DIS_LO     8'h04
`define SCR_OFS_DIS_HI     8'h08
`define SCR_OFS_TRIM_SEL   8'h0C
`define SCR_OFS_TRIM_DATA  8'h10
`define SCR_OFS_PW_BIAS    8'h14
// Reset values
`define SCR_RST_TRIM_SEL   6'h00
`define SCR_RST_PW_BIAS    2'h0
// Synchroniser idle levels: step, start, hold high; reset, cfg low
`define SCR_SYNC_W         70
`define SCR_SYNC_INIT      70'h7

`endif

// File: src/scr_pkg.sv
// Types shared by the serial channel readout and test control block
package scr_pkg;

  typedef enum logic [1:0] {
    SCR_IDLE  = 2'h0,
    SCR_ARMED = 2'h1,
    SCR_SHIFT = 2'h3
  } scr_state_t;

  typedef struct packed {
    logic testOn;
    logic wiredOrEnable;
    logic negThr;
    logic monBufEnable;
  } scr_ctrl_t;

  typedef struct packed {
    logic dreset;
    logic sampleHoldN;
    logic shiftInN;
    logic readoutStepClockN;
  } scr_ro_pins_t;

endpackage

// File: src/scr_readout.sv
// Readout sequencer, trigger gating and configuration chain
// Overview of operation
// - Output mux connects at most one of 64 channels to monitor output.
// - Each step clock cycle moves the one-hot token one channel onward.
// - Stopped step clock keeps the current channel connected.
// - Channel 0 appears at first falling step edge after start accepted.
// - Monitor buffer tri-stated before readout, enabled with channel 0.
// - Token out asserted after rising step edge during last channel.
// - Asserted token input starts readout at next falling step edge.
// - Readout returns to idle on test reset or after a full sequence.
// - Undriven test reset reads as inactive low.
// - With injection enabled, input selector follows output selector.
// - Input selector picks the output channel and at most one channel.
// - A set disable bit suppresses that channel's trigger output.
// - Each enabled discriminator firing gives one fixed-width pulse.
// - Invert control bit selects the inverted discriminator output.
// - Wired-OR enable shows any channel trigger on common trigger pad.
// - Test channel has no trigger output; drives the monitor buffer.
// - Monitor buffer control bit switches the test channel buffer.
// - Each channel holds a 4 bit trim code, 1 mV per step.
// - Config chain captures data on each rising config clock edge.
// - Config chain keeps contents until reshifted; no reset path.
// - Trigger width defaults to 60ns (50ns rounded up to 3 clocks), shorter as width bias rises to 2.
`timescale 1ns/10ps
`include "scr_defines.svh"

module scr_readout (
  input  wire logic                           mclk,
  input  wire logic                           sys_rst,
  input  wire logic                           ce,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [`SCR_ADDR_W-1:0]         paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire scr_pkg::scr_ro_pins_t          roPins,
  input  wire logic                           cfgClk,
  input  wire logic                           cfgDataIn,
  output logic                                cfgDataOut,
  input  wire logic [`SCR_NCHAN-1:0]          discrimRaw,
  output logic      [`SCR_NCHAN-1:0]          channelHitPulse,
  output logic                                commonTrigOut,
  output logic                                commonTrigOe,
  output logic      [`SCR_NCHAN-1:0]          muxSel,
  output logic      [`SCR_NCHAN-1:0]          calSel,
  output logic                                monOutEn,
  output logic                                testBufOn,
  output logic                                shiftOutN,
  output logic                                sampleHold,
  output logic      [`SCR_NCHAN*4-1:0]        trimCode
);
  import scr_pkg::*;

  // Signed offset in mV from a trim code, upper bit selects the sign
  function automatic logic [3:0] trimOffset(input logic [3:0] code);
    logic [3:0] mag;
    mag = {1'b0, code[2:0]};
    trimOffset = code[3] ? mag : 4'(-mag);
  endfunction

  function automatic logic [`SCR_NCHAN-1:0] oneHot(
    input logic                   act,
    input logic [`SCR_IDX_W-1:0]  idx);
    oneHot = act ? (`SCR_NCHAN'(1) << idx) : '0;
  endfunction

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Two-flop synchronisers for every pin input
  logic [`SCR_SYNC_W-1:0] syncA;
  logic [`SCR_SYNC_W-1:0] syncB;
  logic [`SCR_SYNC_W-1:0] syncC;
  logic [`SCR_SYNC_W-1:0] pinsRaw;

  assign pinsRaw = {discrimRaw, cfgDataIn, cfgClk, roPins};

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA <= `SCR_SYNC_INIT;
      syncB <= `SCR_SYNC_INIT;
      syncC <= `SCR_SYNC_INIT;
    end else if (ce) begin
      syncA <= pinsRaw;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  scr_ro_pins_t ro;
  scr_ro_pins_t roLast;
  logic         cfgClkS;
  logic         cfgClkLast;
  logic         cfgDataS;
  logic [`SCR_NCHAN-1:0] discS;
  logic [`SCR_NCHAN-1:0] discLast;
  logic         stepFall;
  logic         stepRise;
  logic         dresetS;

  assign ro         = syncB[3:0];
  assign roLast     = syncC[3:0];
  assign cfgClkS    = syncB[4];
  assign cfgClkLast = syncC[4];
  assign cfgDataS   = syncB[5];
  assign discS      = syncB[`SCR_SYNC_W-1:6];
  assign discLast   = syncC[`SCR_SYNC_W-1:6];
  assign stepFall   = roLast.readoutStepClockN & ~ro.readoutStepClockN;
  assign stepRise   = ~roLast.readoutStepClockN & ro.readoutStepClockN;
  assign dresetS    = ro.dreset;

  // Configuration chain, deliberately without reset
  logic [`SCR_CFG_LEN-1:0] cfg;
  scr_ctrl_t               ctrl;
  logic [`SCR_NCHAN-1:0]   cfgDisable;

  always_ff @(posedge mclk) begin
    if (ce && cfgClkS && !cfgClkLast) begin
      cfg <= {cfg[`SCR_CFG_LEN-2:0], cfgDataS};
    end
  end

  assign ctrl.testOn        = cfg[`SCR_CFG_TESTON];
  assign ctrl.wiredOrEnable = cfg[`SCR_CFG_WOR];
  assign ctrl.negThr        = cfg[`SCR_CFG_NEGTHR];
  assign ctrl.monBufEnable  = cfg[`SCR_CFG_MONBUF];
  assign cfgDisable         = cfg[`SCR_CFG_DIS_HI:`SCR_CFG_DIS_LO];
  assign trimCode           = cfg[`SCR_CFG_TRIM_HI:0];
  assign cfgDataOut         = cfg[`SCR_CFG_LEN-1];

  // Readout sequencer
  scr_state_t            state;
  logic [`SCR_IDX_W-1:0] chanIdx;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state   <= SCR_IDLE;
      chanIdx <= '0;
    end else if (ce) begin
      if (dresetS) begin
        state   <= SCR_IDLE;
        chanIdx <= '0;
      end else begin
        unique case (state)
          SCR_IDLE: begin
            if (stepFall && !ro.shiftInN) begin
              state   <= SCR_SHIFT;
              chanIdx <= '0;
            end else if (stepRise && !ro.shiftInN) begin
              state <= SCR_ARMED;
            end
          end
          SCR_ARMED: begin
            if (stepFall) begin
              state   <= SCR_SHIFT;
              chanIdx <= '0;
            end
          end
          SCR_SHIFT: begin
            if (stepFall) begin
              if (chanIdx == `SCR_LAST_CHAN) begin
                state   <= SCR_IDLE;
                chanIdx <= '0;
              end else begin
                chanIdx <= chanIdx + 1'b1;
              end
            end
          end
          default: begin
            state   <= SCR_IDLE;
            chanIdx <= '0;
          end
        endcase
      end
    end
  end

  logic [`SCR_NCHAN-1:0] next_muxSel;
  logic                  next_active;

  always_comb begin
    next_active = 1'b0;
    next_muxSel = '0;
    if (!dresetS) begin
      unique case (state)
        SCR_IDLE: next_active = stepFall && !ro.shiftInN;
        SCR_ARMED: next_active = stepFall;
        SCR_SHIFT: next_active = !(stepFall && chanIdx == `SCR_LAST_CHAN);
        default: next_active = 1'b0;
      endcase
    end
    if (next_active) begin
      if (state == SCR_SHIFT && stepFall) begin
        next_muxSel = oneHot(1'b1, chanIdx + 1'b1);
      end else if (state == SCR_SHIFT) begin
        next_muxSel = oneHot(1'b1, chanIdx);
      end else begin
        next_muxSel = oneHot(1'b1, '0);
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      muxSel   <= '0;
      calSel   <= '0;
      monOutEn <= 1'b0;
    end else if (ce) begin
      muxSel   <= next_muxSel;
      calSel   <= ctrl.testOn ? next_muxSel : '0;
      monOutEn <= next_active;
    end
  end

  // Token out: low from the rising edge in the last channel until the end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shiftOutN <= 1'b1;
    end else if (ce) begin
      if (dresetS || state != SCR_SHIFT) begin
        shiftOutN <= 1'b1;
      end else if (stepFall && chanIdx == `SCR_LAST_CHAN) begin
        shiftOutN <= 1'b1;
      end else if (stepRise && chanIdx == `SCR_LAST_CHAN) begin
        shiftOutN <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sampleHold <= 1'b0;
      testBufOn  <= 1'b0;
    end else if (ce) begin
      sampleHold <= ~ro.sampleHoldN;
      testBufOn  <= ctrl.monBufEnable;
    end
  end

  // Trigger shaping
  logic [`SCR_PW_W-1:0] pulseWidthBias;
  logic [`SCR_PW_W-1:0] pulseCycles;
  logic [`SCR_PW_W-1:0] pulseCnt [`SCR_NCHAN];
  logic [`SCR_PW_W-1:0] next_pulseCnt [`SCR_NCHAN];
  logic [`SCR_NCHAN-1:0] discPol;
  logic [`SCR_NCHAN-1:0] discPolLast;
  logic [`SCR_NCHAN-1:0] next_hit;

  assign discPol     = discS ^ {`SCR_NCHAN{ctrl.negThr}};
  assign discPolLast = discLast ^ {`SCR_NCHAN{ctrl.negThr}};
  assign pulseCycles = (pulseWidthBias >= `SCR_PW_W'(`SCR_PW_CYCLES))
                       ? `SCR_PW_W'(1)
                       : `SCR_PW_W'(`SCR_PW_CYCLES) - pulseWidthBias;

  always_comb begin
    for (int i = 0; i < `SCR_NCHAN; i++) begin
      next_pulseCnt[i] = pulseCnt[i];
      if (cfgDisable[i]) begin
        next_pulseCnt[i] = '0;
      end else if (discPol[i] && !discPolLast[i] && pulseCnt[i] == '0) begin
        next_pulseCnt[i] = pulseCycles;
      end else if (pulseCnt[i] != '0) begin
        next_pulseCnt[i] = pulseCnt[i] - 1'b1;
      end
      next_hit[i] = next_pulseCnt[i] != '0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `SCR_NCHAN; i++) begin
        pulseCnt[i] <= '0;
      end
      channelHitPulse <= '0;
      commonTrigOe    <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < `SCR_NCHAN; i++) begin
        pulseCnt[i] <= next_pulseCnt[i];
      end
      channelHitPulse <= next_hit;
      commonTrigOe    <= ctrl.wiredOrEnable && (|next_hit);
    end
  end

  assign commonTrigOut = 1'b0;

  // APB slave, zero wait states
  logic [`SCR_IDX_W-1:0] trimSel;
  logic                  apbWr;
  logic                  apbSetup;
  logic [31:0]           next_prdata;
  logic                  next_err;
  logic [3:0]            selTrim;

  assign apbWr    = psel && penable && pwrite;
  assign apbSetup = psel && !penable;
  assign pready   = 1'b1;
  assign selTrim  = trimCode[{trimSel, 2'b00} +: `SCR_TRIM_W];

  always_comb begin
    next_prdata = '0;
    next_err    = 1'b0;
    unique case (paddr)
      `SCR_OFS_STATUS: next_prdata = {18'h0, chanIdx, ~shiftOutN,
        sampleHold, monOutEn, state != SCR_IDLE, ctrl};
      `SCR_OFS_DIS_LO: next_prdata = cfgDisable[31:0];
      `SCR_OFS_DIS_HI: next_prdata = cfgDisable[63:32];
      `SCR_OFS_TRIM_SEL: next_prdata = {26'h0, trimSel};
      `SCR_OFS_TRIM_DATA: next_prdata = {24'h0, selTrim, trimOffset(selTrim)};
      `SCR_OFS_PW_BIAS: next_prdata = {30'h0, pulseWidthBias};
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (ce && apbSetup) begin
      prdata  <= pwrite ? '0 : next_prdata;
      pslverr <= next_err;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      trimSel        <= `SCR_RST_TRIM_SEL;
      pulseWidthBias <= `SCR_RST_PW_BIAS;
    end else if (ce && apbWr) begin
      if (paddr == `SCR_OFS_TRIM_SEL) begin
        trimSel <= pwdata[`SCR_IDX_W-1:0];
      end
      if (paddr == `SCR_OFS_PW_BIAS) begin
        pulseWidthBias <= pwdata[`SCR_PW_W-1:0];
      end
    end
  end

  // Checks
  AST_ONE_HOT: assert property ($onehot0(muxSel))
    else $error("more than one channel switch closed");
  AST_ADVANCE: assert property (ce && !dresetS &&
    state == SCR_SHIFT && stepFall && chanIdx != `SCR_LAST_CHAN
    |=> muxSel == ($past(muxSel) << 1))
    else $error("token did not advance one channel");
  AST_STOPPED: assert property (ce && !dresetS &&
    state == SCR_SHIFT && !stepFall |=> $stable(muxSel))
    else $error("selection moved while step clock stopped");
  AST_FIRST: assert property (ce && !dresetS && state == SCR_ARMED &&
    stepFall |=> muxSel == `SCR_NCHAN'(1) && monOutEn)
    else $error("channel 0 not presented at first falling edge");
  AST_MON_EN: assert property (monOutEn == (muxSel != '0))
    else $error("monitor enable out of step with selection");
  AST_TOKEN_OUT: assert property (ce && !dresetS &&
    state == SCR_SHIFT && stepRise && chanIdx == `SCR_LAST_CHAN
    |=> !shiftOutN)
    else $error("token out not asserted in last channel");
  AST_DRESET: assert property (ce && dresetS |=>
    state == SCR_IDLE ##1 muxSel == '0)
    else $error("test reset did not return readout to idle");
  AST_INJECT: assert property ($onehot0(calSel) &&
    (calSel == '0 || calSel == muxSel))
    else $error("input selector differs from output selector");
  AST_DISABLE: assert property ((channelHitPulse & cfgDisable) == '0)
    else $error("disabled channel produced a trigger");
  AST_WOR: assert property (ce && ctrl.wiredOrEnable && (|next_hit)
    |=> commonTrigOe)
    else $error("common trigger missing with wired-OR enabled");
  AST_WIDTH: assert property (ce && pulseWidthBias == '0 &&
    $rose(channelHitPulse[0]) && !cfgDisable[0] ##1 ce[*2]
    |-> channelHitPulse[0] && $past(channelHitPulse[0]))
    else $error("trigger pulse shorter than default width");

endmodule // scr_readout

// File: testbench/scr_sequencer.sv
// Read-out sequencer model: step clock, start token, hold, test reset
`timescale 1ns/10ps

module scr_sequencer (
  input  wire logic             mclk,
  output scr_pkg::scr_ro_pins_t roPins
);
  import scr_pkg::*;

  // Idle: test reset low, step, token and hold high
  initial roPins = 4'h7;

  // Pin order is {dreset, holdN, tokenN, stepN}
  task automatic drv(input logic [3:0] v, input int n);
    roPins <= v;
    repeat (n) @(posedge mclk);
  endtask

  task automatic arm();
    drv(4'h3, 4);
    drv(4'h2, 4);
    drv(4'h0, 4);
    drv(4'h1, 4);
    drv(4'h3, 4);
  endtask

  // 160 ns step period, high phase may be stretched to stop the clock
  task automatic step(input int stop);
    drv(4'h2, 4);
    drv(4'h3, 4 + stop);
  endtask

  task automatic abort();
    drv(4'hF, 4);
    drv(4'h7, 4);
  endtask
endmodule // scr_sequencer

// File: testbench/tb_serial_channel_readout_test_control.sv
// Self-checking bench for the readout and test control block
`timescale 1ns/10ps
`include "scr_defines.svh"
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin \
  miscompares++; $display("MISMATCH t=%0t got=%0h exp=%0h", \
  $time, (g), (e)); end end

module tb_serial_channel_readout_test_control;
  import scr_pkg::*;
  logic         mclk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         ce = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic         cfgClk = 1'b0;
  logic         cfgDataIn = 1'b0;
  logic [63:0]  discrimRaw = 64'h0;
  logic [31:0]  prdata, rd;
  logic         pready, pslverr, err, cfgDataOut;
  logic         commonTrigOut, commonTrigOe, monOutEn;
  logic         testBufOn, shiftOutN, sampleHold;
  logic [63:0]  channelHitPulse, muxSel, calSel;
  logic [255:0] trimCode;
  logic [323:0] cfg;
  scr_ro_pins_t roPins;
  int           seed = 32'hC097;
  int           miscompares = 0;
  int           checkCount = 0;
  int           c;

  always #10 mclk = ~mclk;

  scr_sequencer i_scr_sequencer (.mclk(mclk), .roPins(roPins));

  scr_readout i_scr_readout (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .roPins(roPins), .cfgClk(cfgClk),
    .cfgDataIn(cfgDataIn), .cfgDataOut(cfgDataOut),
    .discrimRaw(discrimRaw), .channelHitPulse(channelHitPulse),
    .commonTrigOut(commonTrigOut), .commonTrigOe(commonTrigOe),
    .muxSel(muxSel), .calSel(calSel), .monOutEn(monOutEn),
    .testBufOn(testBufOn), .shiftOutN(shiftOutN),
    .sampleHold(sampleHold), .trimCode(trimCode));

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // Expected trim readback: code, then signed offset in mV
  function automatic logic [7:0] trim_rd(input logic [3:0] t);
    logic [3:0] m;
    m = {1'b0, t[2:0]};
    return {t, t[3] ? m : 4'h0 - m};
  endfunction

  task automatic load_cfg();
    for (int i = 323; i >= 0; i--) begin
      cfgDataIn <= cfg[i];
      cfgClk <= 1'b0;
      repeat (25) @(posedge mclk);
      cfgClk <= 1'b1;
      repeat (25) @(posedge mclk);
    end
    cfgClk <= 1'b0;
  endtask

  task automatic readout();
    logic [63:0] e;
    i_scr_sequencer.arm();
    `CHK({monOutEn, muxSel, sampleHold}, {65'h0, 1'b1})
    for (int k = 0; k < 64; k++) begin
      e = 64'h1 << k;
      i_scr_sequencer.step((k == 20 || k == 63) ? 40 : 0);
      `CHK({muxSel, monOutEn, shiftOutN}, {e, 1'b1, k != 63})
      `CHK(calSel, cfg[323] ? e : 64'h0)
    end
    i_scr_sequencer.drv(4'h2, 12);
    `CHK({muxSel, calSel, monOutEn, shiftOutN}, {129'h0, 1'b1})
    i_scr_sequencer.drv(4'h7, 4);
  endtask

  task automatic trig(input int ch, input logic [1:0] b);
    logic [7:0] hits, ors, others;
    int pw;
    logic en;
    apb(1'b1, 8'h14, {30'h0, b});
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rd[1:0], b)
    pw = (b > 2'h2) ? 1 : 3 - b;
    en = !cfg[256 + ch];
    hits = 0;
    ors = 0;
    others = 0;
    discrimRaw[ch] <= !cfg[321];
    repeat (20) begin
      @(posedge mclk);
      hits += channelHitPulse[ch];
      ors += commonTrigOe;
      others += |(channelHitPulse & ~(64'h1 << ch));
    end
    discrimRaw[ch] <= cfg[321];
    repeat (10) @(posedge mclk);
    `CHK(hits, en ? pw : 0)
    `CHK(ors, (en && cfg[322]) ? pw : 0)
    `CHK(commonTrigOut, 1'b0)
    `CHK(others, 0)
  endtask

  initial begin
    #2000000;
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    `CHK({muxSel, monOutEn, shiftOutN, pready}, {65'h0, 2'h3})
    for (int p = 0; p < 2; p++) begin
      for (int j = 0; j < 324; j++)
        cfg[j] = $random(seed);
      cfg[323:321] = p ? 3'h1 : 3'h6;
      cfg[261] = 1'b1;
      cfg[262] = 1'b0;
      cfg[256] = 1'b0;
      load_cfg();
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge mclk);
      `CHK(trimCode, cfg[255:0])
      `CHK({testBufOn, cfgDataOut}, {cfg[320], cfg[323]})
      apb(1'b0, 8'h14, 32'h0);
      `CHK(rd[1:0], 2'h0)
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rd[5:0], {2'h0, cfg[323:320]})
      apb(1'b0, 8'h04, 32'h0);
      `CHK(rd, cfg[287:256])
      apb(1'b0, 8'h08, 32'h0);
      `CHK(rd, cfg[319:288])
      apb(1'b0, 8'h40, 32'h0);
      `CHK({err, rd}, 33'h1_0000_0000)
      c = $random(seed) & 63;
      apb(1'b1, 8'h0C, 32'(c));
      apb(1'b0, 8'h10, 32'h0);
      `CHK(rd[7:0], trim_rd(cfg[4 * c + 3 -: 4]))
      $display("Configuration pass %0d done", p);
      readout();
      i_scr_sequencer.arm();
      repeat (5) i_scr_sequencer.step(0);
      i_scr_sequencer.abort();
      `CHK({muxSel, monOutEn, shiftOutN, sampleHold}, {65'h0, 2'h2})
      i_scr_sequencer.arm();
      i_scr_sequencer.step(0);
      `CHK({muxSel, monOutEn}, {64'h1, 1'b1})
      ce <= 1'b0;
      i_scr_sequencer.step(0);
      ce <= 1'b1;
      i_scr_sequencer.step(0);
      `CHK(muxSel, 64'h2)
      i_scr_sequencer.abort();
      i_scr_sequencer.drv(4'h1, 4);
      i_scr_sequencer.drv(4'h0, 4);
      `CHK({muxSel, monOutEn}, {64'h1, 1'b1})
      i_scr_sequencer.abort();
      $display("Readout pass %0d done", p);
      discrimRaw <= {64{cfg[321]}};
      repeat (10) @(posedge mclk);
      trig(5, 2'h0);
      trig(6, 2'h0);
      trig(0, 2'h0);
      for (int i = 0; i < 4; i++)
        trig($random(seed) & 63, i[1:0]);
      $display("Trigger pass %0d done", p);
    end
    complete_run();
  end
endmodule // tb_serial_channel_readout_test_control
